// >>> inc/fault_flag_pkg.sv
package fault_flag_pkg;
   // Register offsets on the serial control bus
   localparam logic [7:0] FAULT_FLAGS_LOW_OFS       = 8'h26;
   localparam logic [7:0] FAULT_FLAGS_HIGH_OFS      = 8'h27;
   localparam logic [7:0] STATUS_INTERRUPT_MASK_OFS = 8'h28;
   // Reset values
   localparam logic [7:0] FAULT_FLAGS_LOW_RST       = 8'h00;
   localparam logic [7:0] FAULT_FLAGS_HIGH_RST      = 8'h00;
   localparam logic [7:0] STATUS_INTERRUPT_MASK_RST = 8'h00;
   // Low fault flag bit positions
   localparam int BATT_CURRENT_LOOP_BIT        = 7;
   localparam int BUS_INPUT_OVERVOLTAGE_BIT    = 6;
   localparam int BATTERY_OVERVOLTAGE_BIT      = 5;
   localparam int INPUT_OVERCURRENT_BIT        = 4;
   localparam int DISCHARGE_OVERCURRENT_BIT    = 3;
   localparam int CONVERTER_OVERCURRENT_BIT    = 2;
   localparam int SECOND_INPUT_OVERVOLTAGE_BIT = 1;
   localparam int FIRST_INPUT_OVERVOLTAGE_BIT  = 0;
   // High fault flag bit positions
   localparam int SYSTEM_SHORT_BIT              = 7;
   localparam int SYSTEM_OVERVOLTAGE_BIT        = 6;
   localparam int REVERSE_OUT_OVERVOLTAGE_BIT   = 5;
   localparam int REVERSE_OUT_UNDERVOLTAGE_BIT  = 4;
   localparam int DIE_OVERTEMP_BIT              = 2;
   // Mask bit positions
   localparam int INPUT_CURRENT_LIMIT_IRQ_BIT   = 7;
   localparam int INPUT_VOLTAGE_LIMIT_IRQ_BIT   = 6;
   localparam int BUS_WATCHDOG_IRQ_BIT          = 5;
   localparam int WEAK_SOURCE_IRQ_BIT           = 4;
   localparam int POWER_GOOD_IRQ_BIT            = 3;
   localparam int SECOND_INPUT_PRESENCE_IRQ_BIT = 2;
   localparam int FIRST_INPUT_PRESENCE_IRQ_BIT  = 1;
   localparam int BUS_PRESENCE_IRQ_BIT          = 0;
   // Implemented bits and bits that fire on either edge
   localparam logic [7:0] FLAGS_LOW_VALID   = 8'hFF;
   localparam logic [7:0] FLAGS_LOW_ANY     = 8'h80;
   localparam logic [7:0] FLAGS_HIGH_VALID  = 8'hF4;
   localparam logic [7:0] FLAGS_HIGH_ANY    = 8'h00;
   localparam logic [7:0] STATUS_ANY        = 8'h0F;
   // Default serial bus target address
   localparam logic [6:0] TARGET_ADDR_DFLT  = 7'h55;
endpackage

// >>> src/charger_fault_flag_mask_bank.sv
// Notes on behaviour
// (RULE1) Low flag bit 7 sets on entering or leaving battery current loop.
// (RULE2) Bus, second and first input over-voltage flag low bits 6, 1, 0.
// (RULE3) Low flag bit 5 sets on entering battery over-voltage.
// (RULE4) Low flag bit 4 sets on entering input bus over-current.
// (RULE5) Low flag bit 3 sets on entering discharge over-current.
// (RULE6) Low flag bit 2 sets on entering converter switch over-current.
// (RULE7) High flag bit 7 sets when switching halts on system short.
// (RULE8) High flag bit 6 sets when switching halts on system over-voltage.
// (RULE9) High flag bit 5 sets when reverse output stops on bus over-voltage.
// (RULE10) High flag bit 4 sets when reverse output halts on bus undervoltage.
// (RULE11) High flag bit 2 sets on die over-temp rise; bits 3,1,0 read zero.
// (RULE12) Flag bits are read-only and clear at power-on reset.
// (RULE13) Mask bit 7 low lets current limit entry pulse the interrupt.
// (RULE14) Mask bit 6 high blocks voltage limit entry interrupt pulse.
// (RULE15) Mask bit 5 gates the watchdog expiry interrupt pulse.
// (RULE16) Mask bit 4 gates the weak source interrupt pulse.
// (RULE17) Mask bit 3 gates the power-good toggle interrupt pulse.
// (RULE18) Mask bits 2 and 1 gate second and first input presence changes.
// (RULE19) Mask clears on register reset command and at power-on.
// (RULE20) A flag clears once its register is read; later events set it again.
module charger_fault_flag_mask_bank
   import fault_flag_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DFLT
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Serial control bus, open drain
   input  wire logic scl,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   // Register reset command, one clk pulse
   input  wire logic regResetCmd,
   // Fault detector levels, asynchronous
   input  wire logic battCurrentLoopEvent,
   input  wire logic busInputOvervoltageEvent,
   input  wire logic batteryOvervoltageEvent,
   input  wire logic inputOvercurrentEvent,
   input  wire logic dischargeOvercurrentEvent,
   input  wire logic converterOvercurrentEvent,
   input  wire logic secondInputOvervoltageEvent,
   input  wire logic firstInputOvervoltageEvent,
   input  wire logic systemShortEvent,
   input  wire logic systemOvervoltageEvent,
   input  wire logic reverseOutOvervoltageEvent,
   input  wire logic reverseOutUndervoltageEvent,
   input  wire logic dieOvertempEvent,
   // Charger status levels, asynchronous
   input  wire logic inputCurrentLimit,
   input  wire logic inputVoltageLimit,
   input  wire logic busWatchdogExpired,
   input  wire logic weakSource,
   input  wire logic powerGood,
   input  wire logic secondInputPresent,
   input  wire logic firstInputPresent,
   input  wire logic busPresent,
   // Interrupt pulse toward the pin driver
   output logic      intPulse
);

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEV  = 7'h02,
      ST_REG  = 7'h04,
      ST_WR   = 7'h08,
      ST_RD   = 7'h10,
      ST_ACK  = 7'h20,
      ST_MACK = 7'h40
   } bus_state_e;

   localparam int SYNC_W = 26;
   // Bus lines idle high; resetting their stages low would fake an edge
   localparam logic [SYNC_W-1:0] SYNC_RST = {2'b11, {(SYNC_W-2){1'b0}}};

   // Edge events; bits in anyMask fire on both edges, others on rise only
   function automatic logic [7:0] edgeEvents(input logic [7:0] cur,
                                             input logic [7:0] prev,
                                             input logic [7:0] anyMask);
      edgeEvents = ((cur ^ prev) & anyMask) | (cur & ~prev & ~anyMask);
   endfunction

   // Register read mux; reserved and unmapped bytes read zero
   function automatic logic [7:0] readReg(input logic [7:0] ofs,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic [7:0] msk);
      if (ofs == FAULT_FLAGS_LOW_OFS) begin
         readReg = lo;
      end else if (ofs == FAULT_FLAGS_HIGH_OFS) begin
         readReg = hi & FLAGS_HIGH_VALID; // see (RULE11)
      end else if (ofs == STATUS_INTERRUPT_MASK_OFS) begin
         readReg = msk;
      end else begin
         readReg = 8'h00;
      end
   endfunction

   logic [7:0]        faultRawLo;
   logic [7:0]        faultRawHi;
   logic [7:0]        statusRaw;
   logic [SYNC_W-1:0] asyncIn;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] prev_q;

   // Input vectors in register bit order
   assign faultRawLo = {battCurrentLoopEvent, busInputOvervoltageEvent,
                        batteryOvervoltageEvent, inputOvercurrentEvent,
                        dischargeOvercurrentEvent, converterOvercurrentEvent,
                        secondInputOvervoltageEvent,
                        firstInputOvervoltageEvent};
   assign faultRawHi = {systemShortEvent, systemOvervoltageEvent,
                        reverseOutOvervoltageEvent,
                        reverseOutUndervoltageEvent, 1'b0, dieOvertempEvent,
                        2'b00};
   assign statusRaw  = {inputCurrentLimit, inputVoltageLimit,
                        busWatchdogExpired, weakSource, powerGood,
                        secondInputPresent, firstInputPresent, busPresent};
   assign asyncIn    = {scl, sdaIn, statusRaw, faultRawHi, faultRawLo};

   // Two-flop synchronisers, third stage only for edge finding
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         prev_q  <= SYNC_RST;
      end else begin
         sync1_q <= asyncIn;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   logic       sclS;
   logic       sdaS;
   logic       sclRise;
   logic       sclFall;
   logic       startCond;
   logic       stopCond;
   logic [7:0] setLo;
   logic [7:0] setHi;
   logic [7:0] statusEvt;

   // Bus conditions and detector events from synchronised levels
   assign sclS      = sync2_q[25];
   assign sdaS      = sync2_q[24];
   assign sclRise   = sclS & ~prev_q[25];
   assign sclFall   = ~sclS & prev_q[25];
   assign startCond = sclS & prev_q[25] & ~sdaS & prev_q[24];
   assign stopCond  = sclS & prev_q[25] & sdaS & ~prev_q[24];
   // see (RULE1) (RULE2) (RULE3) (RULE4) (RULE5) (RULE6)
   assign setLo     = edgeEvents(sync2_q[7:0], prev_q[7:0], FLAGS_LOW_ANY)
                      & FLAGS_LOW_VALID;
   // see (RULE7) (RULE8) (RULE9) (RULE10) (RULE11)
   assign setHi     = edgeEvents(sync2_q[15:8], prev_q[15:8], FLAGS_HIGH_ANY)
                      & FLAGS_HIGH_VALID;
   assign statusEvt = edgeEvents(sync2_q[23:16], prev_q[23:16], STATUS_ANY);

   bus_state_e state_q, state_d;
   bus_state_e ackTo_q, ackTo_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic       oe_q, oe_d;
   logic [7:0] flagLo_q, flagLo_d;
   logic [7:0] flagHi_q, flagHi_d;
   logic [7:0] mask_q, mask_d;
   logic       intPulse_q, intPulse_d;
   logic [7:0] rdByte;
   logic       clrLo;
   logic       clrHi;
   logic       wrMask;

   // Bus engine: shifts on scl rise, drives sda only after scl falls
   always_comb begin
      state_d  = state_q;
      ackTo_d  = ackTo_q;
      bitCnt_d = bitCnt_q;
      shift_d  = shift_q;
      ptr_d    = ptr_q;
      oe_d     = oe_q;
      clrLo    = 1'b0;
      clrHi    = 1'b0;
      wrMask   = 1'b0;
      rdByte   = readReg(ptr_q, flagLo_q, flagHi_q, mask_q);
      if (startCond) begin
         state_d  = ST_DEV;
         bitCnt_d = 4'h0;
         oe_d     = 1'b0;
      end else if (stopCond) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (sclRise) begin
         case (state_q)
            ST_DEV, ST_REG, ST_WR: begin
               shift_d  = {shift_q[6:0], sdaS};
               bitCnt_d = bitCnt_q + 4'h1;
            end
            ST_MACK: begin
               // Controller not-acknowledge ends the read burst
               state_d = sdaS ? ST_IDLE : ST_ACK;
               ackTo_d = ST_RD;
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end else if (sclFall) begin
         case (state_q)
            ST_DEV: begin
               if (bitCnt_q == 4'h8) begin
                  if (shift_q[7:1] == TARGET_ADDR) begin
                     oe_d    = 1'b1;
                     state_d = ST_ACK;
                     ackTo_d = shift_q[0] ? ST_RD : ST_REG;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_REG: begin
               if (bitCnt_q == 4'h8) begin
                  ptr_d   = shift_q;
                  oe_d    = 1'b1;
                  state_d = ST_ACK;
                  ackTo_d = ST_WR;
               end
            end
            ST_WR: begin
               if (bitCnt_q == 4'h8) begin
                  // Flag registers ignore writes, see (RULE12)
                  wrMask  = (ptr_q == STATUS_INTERRUPT_MASK_OFS);
                  ptr_d   = ptr_q + 8'h01;
                  oe_d    = 1'b1;
                  state_d = ST_ACK;
                  ackTo_d = ST_WR;
               end
            end
            ST_ACK: begin
               bitCnt_d = 4'h0;
               oe_d     = 1'b0;
               state_d  = ackTo_q;
               if (ackTo_q == ST_RD) begin
                  shift_d  = rdByte;
                  oe_d     = ~rdByte[7];
                  bitCnt_d = 4'h1;
                  ptr_d    = ptr_q + 8'h01;
                  clrLo    = (ptr_q == FAULT_FLAGS_LOW_OFS); // see (RULE20)
                  clrHi    = (ptr_q == FAULT_FLAGS_HIGH_OFS); // see (RULE20)
               end
            end
            ST_RD: begin
               if (bitCnt_q == 4'h8) begin
                  oe_d    = 1'b0;
                  state_d = ST_MACK;
               end else begin
                  oe_d     = ~shift_q[3'h7 - bitCnt_q[2:0]];
                  bitCnt_d = bitCnt_q + 4'h1;
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   // Flags: capture on read, then clear; a new event wins over the clear
   always_comb begin
      flagLo_d = (flagLo_q & ~{8{clrLo}}) | setLo; // see (RULE20)
      flagHi_d = (flagHi_q & ~{8{clrHi}}) | setHi; // see (RULE20)
      mask_d   = mask_q;
      if (regResetCmd) begin
         mask_d = STATUS_INTERRUPT_MASK_RST; // see (RULE19)
      end else if (wrMask) begin
         mask_d = shift_q;
      end
      // Mask bit high suppresses that status event
      // see (RULE13) (RULE14) (RULE15) (RULE16) (RULE17) (RULE18)
      intPulse_d = |(statusEvt & ~mask_q);
   end

   // State registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         ackTo_q    <= ST_IDLE;
         bitCnt_q   <= 4'h0;
         shift_q    <= 8'h00;
         ptr_q      <= 8'h00;
         oe_q       <= 1'b0;
         flagLo_q   <= FAULT_FLAGS_LOW_RST; // see (RULE12)
         flagHi_q   <= FAULT_FLAGS_HIGH_RST; // see (RULE12)
         mask_q     <= STATUS_INTERRUPT_MASK_RST; // see (RULE19)
         intPulse_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         ackTo_q    <= ackTo_d;
         bitCnt_q   <= bitCnt_d;
         shift_q    <= shift_d;
         ptr_q      <= ptr_d;
         oe_q       <= oe_d;
         flagLo_q   <= flagLo_d;
         flagHi_q   <= flagHi_d;
         mask_q     <= mask_d;
         intPulse_q <= intPulse_d;
      end
   end

   // Open drain: the data level is always low, only the enable moves
   assign sdaOut   = 1'b0;
   assign sdaOe    = oe_q;
   assign intPulse = intPulse_q;

endmodule

// >>> test/charger_fault_flag_mask_bank_assertions.sv
module charger_fault_flag_mask_bank_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bus and command
   input wire logic scl,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic regResetCmd,
   // Status levels
   input wire logic inputCurrentLimit,
   input wire logic inputVoltageLimit,
   input wire logic busWatchdogExpired,
   input wire logic weakSource,
   input wire logic powerGood,
   input wire logic secondInputPresent,
   input wire logic firstInputPresent,
   input wire logic busPresent,
   // Interrupt
   input wire logic intPulse
);
   logic       maskClear_q;
   logic       maskClear_d;
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   // Mask is only known clear until the bus answers again
   always_comb begin
      maskClear_d = (maskClear_q | regResetCmd) & ~sdaOe;
      quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
   end
   // Cycles since any status input moved
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         maskClear_q <= 1'b1;
         quiet_q <= 4'hF;
      end else begin
         maskClear_q <= maskClear_d;
         quiet_q <= $changed({inputCurrentLimit, inputVoltageLimit,
            busWatchdogExpired, weakSource, powerGood, secondInputPresent,
            firstInputPresent, busPresent}) ? 4'h0 : quiet_d;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_icl_pulse: assert property (
      maskClear_q && $rose(inputCurrentLimit) |-> ##[1:6] intPulse)
      else $error("current limit gave no pulse");
   a_ivl_pulse: assert property (
      maskClear_q && $rose(inputVoltageLimit) |-> ##[1:6] intPulse)
      else $error("voltage limit gave no pulse");
   a_wdog_pulse: assert property (
      maskClear_q && $rose(busWatchdogExpired) |-> ##[1:6] intPulse)
      else $error("watchdog gave no pulse");
   a_weak_pulse: assert property (
      maskClear_q && $rose(weakSource) |-> ##[1:6] intPulse)
      else $error("weak source gave no pulse");
   a_pgood_pulse: assert property (
      maskClear_q && $changed(powerGood) |-> ##[1:6] intPulse)
      else $error("power good gave no pulse");
   a_in2_pulse: assert property (
      maskClear_q && $changed(secondInputPresent) |-> ##[1:6] intPulse)
      else $error("second input gave no pulse");
   a_in1_pulse: assert property (
      maskClear_q && $changed(firstInputPresent) |-> ##[1:6] intPulse)
      else $error("first input gave no pulse");
   a_bus_pulse: assert property (
      maskClear_q && $changed(busPresent) |-> ##[1:6] intPulse)
      else $error("bus presence gave no pulse");
   a_pulse_cause: assert property (intPulse |-> quiet_q < 4'h8)
      else $error("pulse without status change");
   a_sda_low: assert property (sdaOut == 1'b0)
      else $error("data value not low");
   // Data enable moves only while the bus clock is low
   a_oe_scl_low: assert property ($changed(sdaOe) |-> !scl)
      else $error("data enable moved while clock high");
   // Main scenarios reached
   c_pulse: cover property (intPulse);
   c_answer: cover property ($rose(sdaOe));
   c_regreset: cover property (regResetCmd);
endmodule

bind charger_fault_flag_mask_bank charger_fault_flag_mask_bank_chk
   u_charger_fault_flag_mask_bank_chk (.clk, .sys_rst, .scl, .sdaOut, .sdaOe,
   .regResetCmd, .inputCurrentLimit, .inputVoltageLimit, .busWatchdogExpired,
   .weakSource, .powerGood, .secondInputPresent, .firstInputPresent,
   .busPresent, .intPulse);

// >>> test/host_bus_model.sv
module host_bus_model (
   // Link toward the device
   output logic      scl,
   output logic      sdaPull,
   input  wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 10ps;
   localparam real HALF = 62.5;
   // Idle bus: clock stands high, data released
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   // Data moves well after the clock fall so sync flops never race it
   task automatic bitx(input logic b, output logic r);
      #15 sdaPull = ~b;
      #(HALF - 15) scl = 1'b1;
      #(HALF / 2) r = sdaLine;
      #(HALF / 2) scl = 1'b0;
   endtask
   task automatic start();
      #15 sdaPull = 1'b0;
      #(HALF - 15) scl = 1'b1;
      #(HALF) sdaPull = 1'b1;
      #(HALF) scl = 1'b0;
   endtask
   task automatic stop();
      #15 sdaPull = 1'b1;
      #(HALF - 15) scl = 1'b1;
      #(HALF) sdaPull = 1'b0;
      #(HALF);
   endtask
   // Eight bits MSB first, then the ninth bit given by last
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(last, a);
      ack = ~a;
   endtask
endmodule

// >>> test/tb_charger_fault_flag_mask_bank.sv
module tb_charger_fault_flag_mask_bank
   import fault_flag_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, sys_rst, regResetCmd, scl, sdaPull, sdaLine;
   logic        sdaOut, sdaOe, intPulse;
   logic [12:0] faults;
   logic [7:0]  stat;
   int          fails, numChecks;
   // Pull-up on the shared data line
   assign sdaLine = ~(sdaPull | sdaOe);
   charger_fault_flag_mask_bank u_charger_fault_flag_mask_bank (
      .clk, .sys_rst, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOe, .regResetCmd,
      .battCurrentLoopEvent(faults[0]), .busInputOvervoltageEvent(faults[1]),
      .batteryOvervoltageEvent(faults[2]), .inputOvercurrentEvent(faults[3]),
      .dischargeOvercurrentEvent(faults[4]),
      .converterOvercurrentEvent(faults[5]),
      .secondInputOvervoltageEvent(faults[6]),
      .firstInputOvervoltageEvent(faults[7]), .systemShortEvent(faults[8]),
      .systemOvervoltageEvent(faults[9]),
      .reverseOutOvervoltageEvent(faults[10]),
      .reverseOutUndervoltageEvent(faults[11]),
      .dieOvertempEvent(faults[12]), .inputCurrentLimit(stat[7]),
      .inputVoltageLimit(stat[6]), .busWatchdogExpired(stat[5]),
      .weakSource(stat[4]), .powerGood(stat[3]),
      .secondInputPresent(stat[2]), .firstInputPresent(stat[1]),
      .busPresent(stat[0]), .intPulse);
   host_bus_model u_host_bus_model (.scl, .sdaPull, .sdaLine);
   // System clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      numChecks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic       k;
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT, 1'b0}, 1'b1, r, k);
      chk("address ack", 8'h01, {7'h00, k});
      u_host_bus_model.xfer(a, 1'b1, r, k);
      u_host_bus_model.xfer(d, 1'b1, r, k);
      u_host_bus_model.stop();
   endtask
   task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic       k;
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT, 1'b0}, 1'b1, r, k);
      u_host_bus_model.xfer(a, 1'b1, r, k);
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT, 1'b1}, 1'b1, r, k);
      u_host_bus_model.xfer(8'hFF, 1'b1, d, k);
      u_host_bus_model.stop();
   endtask
   // Pulse seen anywhere in a ten cycle window, sampled mid-cycle
   task automatic expPulse(input string nm, input logic e);
      logic s;
      s = 1'b0;
      repeat (10) begin
         @(negedge clk);
         if (intPulse === 1'b1)
            s = 1'b1;
      end
      chk(nm, {7'h00, e}, {7'h00, s});
   endtask
   task automatic t_status(input logic blk);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) stat[i] <= 1'b1;
         expPulse("pulse on rise", ~blk); // to
         @(posedge clk) stat[i] <= 1'b0;
         expPulse("pulse on fall", ~blk && i < 4);
      end
   endtask
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] r;
      logic       k;
      rdReg(FAULT_FLAGS_LOW_OFS, d);
      chk("low flags", FAULT_FLAGS_LOW_RST, d);
      rdReg(FAULT_FLAGS_HIGH_OFS, d);
      chk("high flags", FAULT_FLAGS_HIGH_RST, d);
      rdReg(STATUS_INTERRUPT_MASK_OFS, d);
      chk("mask", STATUS_INTERRUPT_MASK_RST, d);
      wrReg(FAULT_FLAGS_LOW_OFS, 8'hFF);
      rdReg(FAULT_FLAGS_LOW_OFS, d);
      chk("low flags written", 8'h00, d);
      wrReg(STATUS_INTERRUPT_MASK_OFS, 8'hA5);
      rdReg(STATUS_INTERRUPT_MASK_OFS, d);
      chk("mask written", 8'hA5, d); // to
      rdReg(8'h30, d);
      chk("unmapped", 8'h00, d);
      // Burst read walks the pointer from the high flags into the mask
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT, 1'b0}, 1'b1, r, k);
      u_host_bus_model.xfer(FAULT_FLAGS_HIGH_OFS, 1'b1, r, k);
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT, 1'b1}, 1'b1, r, k);
      u_host_bus_model.xfer(8'hFF, 1'b0, d, k);
      chk("burst high flags", FAULT_FLAGS_HIGH_RST, d);
      u_host_bus_model.xfer(8'hFF, 1'b1, d, k);
      chk("burst mask", 8'hA5, d); // to
      u_host_bus_model.stop();
      // A foreign target address gets no acknowledge
      u_host_bus_model.start();
      u_host_bus_model.xfer({TARGET_ADDR_DFLT ^ 7'h01, 1'b0}, 1'b1, r, k);
      chk("foreign address ack", 8'h00, {7'h00, k});
      u_host_bus_model.stop();
   endtask
   task automatic t_faults();
      logic [7:0] d;
      logic [7:0] a;
      int         b;
      for (int i = 0; i < 13; i++) begin
         a = (i < 8) ? FAULT_FLAGS_LOW_OFS : FAULT_FLAGS_HIGH_OFS;
         b = (i < 8) ? 7 - i : ((i < 12) ? 15 - i : 2);
         @(posedge clk) faults[i] <= 1'b1;
         repeat (6) @(posedge clk);
         rdReg(a, d);
         chk("flag set", 8'h01 << b, d); // to
         rdReg(a, d);
         chk("flag read clear", 8'h00, d);
         @(posedge clk) faults[i] <= 1'b0;
         repeat (6) @(posedge clk);
         rdReg(a, d);
         chk("flag on exit", (i == 0) ? 8'h80 : 8'h00, d);
      end
   endtask
   task automatic t_regreset();
      logic [7:0] d;
      wrReg(STATUS_INTERRUPT_MASK_OFS, 8'hFF);
      @(posedge clk) regResetCmd <= 1'b1;
      @(posedge clk) regResetCmd <= 1'b0;
      rdReg(STATUS_INTERRUPT_MASK_OFS, d);
      chk("mask after cmd", STATUS_INTERRUPT_MASK_RST, d);
      @(posedge clk) stat[7] <= 1'b1;
      expPulse("pulse after cmd", 1'b1);
   endtask
   // Main sequence: unmasked edges first, before any bus traffic
   initial begin
      sys_rst = 1'b1;
      regResetCmd = 1'b0;
      faults = '0;
      stat = '0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_status(1'b0);
      t_regs();
      wrReg(STATUS_INTERRUPT_MASK_OFS, 8'hFF);
      t_status(1'b1);
      t_faults();
      t_regreset();
      wrap_up();
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      $display("[ERR] run length expected finish seen timeout");
      wrap_up();
   end
endmodule
